// ---- src/rre_pkg.sv ----
/*
  Shared constants and carrier types for the return and rotate execute block.
  Assumes a byte-addressed APB with 32-bit data, each register on one word.
*/
package rre_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR     = 8'h00;
  localparam logic [7:0] OFF_CTRL      = 8'h04;
  localparam logic [7:0] OFF_ACC       = 8'h08;
  localparam logic [7:0] OFF_FLAGS     = 8'h0c;
  localparam logic [7:0] OFF_BANK      = 8'h10;
  localparam logic [7:0] OFF_PC        = 8'h14;
  localparam logic [7:0] OFF_STACK     = 8'h18;
  localparam logic [7:0] OFF_ACC_SH    = 8'h1c;
  localparam logic [7:0] OFF_FLAGS_SH  = 8'h20;
  localparam logic [7:0] OFF_BANK_SH   = 8'h24;
  localparam logic [7:0] OFF_UPPER     = 8'h28;
  localparam logic [7:0] OFF_HIGH      = 8'h2c;
  localparam logic [7:0] OFF_FILE_ADDR = 8'h30;
  localparam logic [7:0] OFF_FILE_DATA = 8'h34;

  // ----------------------------------------------------------------
  // Control register bits
  // ----------------------------------------------------------------
  localparam int CTRL_BUSY_BIT  = 0;
  localparam int CTRL_ILL_BIT   = 1;
  localparam int CTRL_STK_BIT   = 2;

  // ----------------------------------------------------------------
  // Opcode patterns and widths
  // ----------------------------------------------------------------
  localparam logic [14:0] OP_RET_PAT   = 15'h0009;
  localparam logic [5:0]  OP_ROT_PAT   = 6'h0d;
  localparam int          PC_W         = 21;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]      RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC   = 21'h000000;
  localparam logic [15:0]     RST_OP   = 16'h0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } rre_flags_s;

  localparam rre_flags_s RST_FLAGS = 5'h00;

  typedef struct packed {
    logic       is_ret;
    logic       is_rot;
    logic       s;
    logic       d;
    logic       a;
    logic [7:0] f;
  } rre_op_s;

endpackage

// ---- src/rre_file_mem.sv ----
/*
  File register memory with one write port and a registered read port.
  Assumes the owner arbitrates so only one agent drives the ports at a time.
*/
`timescale 1ns/1ns
module rre_file_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // Read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [2**AW];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Read data one edge after the address
  always_ff @(posedge clk_in) begin
    rdata_out <= mem[raddr_in];
  end

endmodule

// ---- src/rre_exec.sv ----
/*
  Execute logic for subroutine return and rotate left through carry,
  with core state reachable over an APB slave.
  Assumes one 20 MHz clock and a synchronous active-high reset; an
  instruction cycle is four clocks (phases one to four).
*/
// The register offsets and register access over APB were decided locally.
// Functional notes
// RULE1: Opcode 0000 0000 0001 001s is the return, bit 0 picks shadow restore.
// RULE2: A return pops the stack into the program counter and takes two cycles, the second idle.
// RULE3: With the option set the return copies the three shadows back into their registers.
// RULE4: With the option clear the return leaves accumulator, flags and bank pointer alone.
// RULE5: A return never touches the two jump latches nor changes flags except by restore.
// RULE6: Opcodes starting 001101 rotate left through carry with d at bit 9, a at bit 8, f below.
// RULE7: The rotate shifts each bit up by one, old bit 7 into carry, old carry into bit 0.
// RULE8: The rotate result goes to the accumulator when d is 0, else back to the file register.
// RULE9: With a clear the operand comes from the access bank, ignoring the bank pointer.
// RULE10: With a set the operand bank is the one the bank pointer names.
// RULE11: The rotate runs in one cycle of read, process and write and updates carry, N and Z.
// RULE12: The rotate sets N from result bit 7 and Z only when the result is zero.
`timescale 1ns/1ns
module rre_exec #(
  parameter int STACK_DEPTH = 31,
  parameter int BANKS       = 16
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  localparam int BW  = $clog2(BANKS);
  localparam int AW  = BW + 8;
  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam int PW  = rre_pkg::PC_W;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (BANKS < 2 || BANKS > 16 || (BANKS & (BANKS - 1)) != 0) begin : g_bad_banks
    $error("BANKS must be a power of two from 2 to 16");
  end
  if (STACK_DEPTH < 1 || STACK_DEPTH > 255) begin : g_bad_stack
    $error("STACK_DEPTH must be 1 to 255");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b100
  } rre_state_e;

  function automatic rre_pkg::rre_op_s decode(input logic [15:0] op);
    rre_pkg::rre_op_s r;
    // RULE1: return pattern match
    r.is_ret = (op[15:1] == rre_pkg::OP_RET_PAT);
    // RULE6: rotate pattern and fields
    r.is_rot = (op[15:10] == rre_pkg::OP_ROT_PAT);
    r.s      = op[0];
    r.d      = op[9];
    r.a      = op[8];
    r.f      = op[7:0];
    return r;
  endfunction

  rre_state_e            state;
  logic [1:0]            phase;
  logic [15:0]           opcode;
  rre_pkg::rre_op_s      dec;
  logic [7:0]            operand;
  logic [7:0]            result;
  logic                  carry_out;
  logic [7:0]            accumulator;
  rre_pkg::rre_flags_s   flags;
  logic [7:0]            bank_pointer;
  logic [PW-1:0]         program_counter;
  logic [7:0]            accumulator_shadow;
  rre_pkg::rre_flags_s   flags_shadow;
  logic [7:0]            bank_shadow;
  logic [7:0]            upper_jump_latch;
  logic [7:0]            high_jump_latch;
  logic [AW-1:0]         file_addr;
  logic                  ill_flag;
  logic                  stk_flag;
  logic [PW-1:0]         stack_mem [STACK_DEPTH];
  logic [SPW-1:0]        stack_ptr;
  logic [PW-1:0]         stack_head;
  logic [BW-1:0]         op_bank;
  logic [AW-1:0]         op_addr;
  logic                  busy;
  logic                  apb_access;
  logic                  wr_commit;
  logic                  stall;
  logic                  mapped;
  logic [31:0]           read_mux;
  logic                  mem_we;
  logic [AW-1:0]         mem_waddr;
  logic [7:0]            mem_wdata;
  logic [AW-1:0]         mem_raddr;
  logic [7:0]            mem_rdata;
  logic                  q4_exec;
  logic                  ret_pop;
  logic                  rot_end;
  logic                  push_req;

  assign dec        = decode(opcode);
  assign busy       = (state != ST_IDLE);
  assign apb_access = psel_in & penable_in;
  assign wr_commit  = apb_access & pready_out & pwrite_in;
  assign q4_exec    = (state == ST_EXEC) && (phase == rre_pkg::PHASE_LAST);
  // RULE2: pop on phase four
  assign ret_pop    = q4_exec & dec.is_ret;
  assign rot_end    = q4_exec & dec.is_rot;
  assign push_req   = wr_commit && (paddr_in == rre_pkg::OFF_STACK);
  assign stack_head = (stack_ptr == '0) ? rre_pkg::RST_PC : stack_mem[stack_ptr - 1'b1];

  // ----------------------------------------------------------------
  // Operand addressing
  // ----------------------------------------------------------------
  // RULE9: access bank split
  // RULE10: bank pointer bank
  always_comb begin
    if (dec.a) begin
      op_bank = bank_pointer[BW-1:0];
    end else if (dec.f >= rre_pkg::ACCESS_SPLIT) begin
      op_bank = BW'(BANKS - 1);
    end else begin
      op_bank = '0;
    end
  end
  assign op_addr   = {op_bank, dec.f};
  // Core owns the memory while busy, so software access waits
  assign mem_raddr = busy ? op_addr : file_addr;
  // RULE8: file destination write
  assign mem_we    = (rot_end & dec.d) |
                     (wr_commit && (paddr_in == rre_pkg::OFF_FILE_DATA));
  assign mem_waddr = busy ? op_addr : file_addr;
  assign mem_wdata = busy ? result : pwdata_in[7:0];

  rre_file_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .clk_in    (clk_in),
    .we_in     (mem_we),
    .waddr_in  (mem_waddr),
    .wdata_in  (mem_wdata),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state  <= ST_IDLE;
      phase  <= 2'h0;
      opcode <= rre_pkg::RST_OP;
    end else begin
      case (state)
        ST_IDLE: begin
          phase <= 2'h0;
          if (wr_commit && (paddr_in == rre_pkg::OFF_INSTR)) begin
            opcode <= pwdata_in[15:0];
            state  <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          phase <= phase + 2'h1;
          if (phase == rre_pkg::PHASE_LAST) begin
            // RULE2: idle second cycle
            state <= dec.is_ret ? ST_WAIT : ST_IDLE;
          end
        end
        ST_WAIT: begin
          phase <= phase + 2'h1;
          if (phase == rre_pkg::PHASE_LAST) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          phase <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Rotate datapath
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      operand   <= rre_pkg::RST_BYTE;
      result    <= rre_pkg::RST_BYTE;
      carry_out <= 1'b0;
    end else if (state == ST_EXEC && dec.is_rot) begin
      // RULE11: read in Q2, process in Q3
      if (phase == 2'h1) begin
        operand <= mem_rdata;
      end
      if (phase == 2'h2) begin
        // RULE7: shift through carry
        result    <= {operand[6:0], flags.c};
        carry_out <= operand[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, flags and bank pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      accumulator  <= rre_pkg::RST_BYTE;
      flags        <= rre_pkg::RST_FLAGS;
      bank_pointer <= rre_pkg::RST_BYTE;
    end else if (ret_pop) begin
      // RULE3: shadow restore
      // RULE4: no restore when clear
      // RULE5: flags only via restore
      if (dec.s) begin
        accumulator  <= accumulator_shadow;
        flags        <= flags_shadow;
        bank_pointer <= bank_shadow;
      end
    end else if (rot_end) begin
      // RULE8: accumulator destination
      if (!dec.d) begin
        accumulator <= result;
      end
      // RULE11: flag update
      // RULE12: N and Z rule
      flags.c <= carry_out;
      flags.n <= result[7];
      flags.z <= (result == 8'h00);
    end else if (wr_commit) begin
      case (paddr_in)
        rre_pkg::OFF_ACC:   accumulator  <= pwdata_in[7:0];
        rre_pkg::OFF_FLAGS: flags        <= pwdata_in[4:0];
        rre_pkg::OFF_BANK:  bank_pointer <= {4'h0, pwdata_in[3:0]};
        default:            accumulator  <= accumulator;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      program_counter <= rre_pkg::RST_PC;
      stack_ptr       <= '0;
    end else if (ret_pop) begin
      // RULE2: head into counter
      program_counter <= stack_head;
      if (stack_ptr != '0) begin
        stack_ptr <= stack_ptr - 1'b1;
      end
    end else if (push_req && stack_ptr != SPW'(STACK_DEPTH)) begin
      stack_mem[stack_ptr] <= pwdata_in[PW-1:0];
      stack_ptr            <= stack_ptr + 1'b1;
    end else if (wr_commit && paddr_in == rre_pkg::OFF_PC) begin
      program_counter <= pwdata_in[PW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Shadows, jump latches, file pointer
  // ----------------------------------------------------------------
  // RULE5: latches untouched by return
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      accumulator_shadow <= rre_pkg::RST_BYTE;
      flags_shadow       <= rre_pkg::RST_FLAGS;
      bank_shadow        <= rre_pkg::RST_BYTE;
      upper_jump_latch   <= rre_pkg::RST_BYTE;
      high_jump_latch    <= rre_pkg::RST_BYTE;
      file_addr          <= '0;
    end else if (wr_commit) begin
      case (paddr_in)
        rre_pkg::OFF_ACC_SH:    accumulator_shadow <= pwdata_in[7:0];
        rre_pkg::OFF_FLAGS_SH:  flags_shadow       <= pwdata_in[4:0];
        rre_pkg::OFF_BANK_SH:   bank_shadow        <= {4'h0, pwdata_in[3:0]};
        rre_pkg::OFF_UPPER:     upper_jump_latch   <= {3'h0, pwdata_in[4:0]};
        rre_pkg::OFF_HIGH:      high_jump_latch    <= pwdata_in[7:0];
        rre_pkg::OFF_FILE_ADDR: file_addr          <= pwdata_in[AW-1:0];
        default:                file_addr          <= file_addr;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky error flags, set beats write-one clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ill_flag <= 1'b0;
      stk_flag <= 1'b0;
    end else begin
      if (state == ST_EXEC && phase == 2'h0 && !dec.is_ret && !dec.is_rot) begin
        ill_flag <= 1'b1;
      end else if (wr_commit && paddr_in == rre_pkg::OFF_CTRL &&
                   pwdata_in[rre_pkg::CTRL_ILL_BIT]) begin
        ill_flag <= 1'b0;
      end
      if ((ret_pop && stack_ptr == '0) ||
          (push_req && stack_ptr == SPW'(STACK_DEPTH))) begin
        stk_flag <= 1'b1;
      end else if (wr_commit && paddr_in == rre_pkg::OFF_CTRL &&
                   pwdata_in[rre_pkg::CTRL_STK_BIT]) begin
        stk_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read decode
  // ----------------------------------------------------------------
  always_comb begin
    read_mux = 32'h0;
    mapped   = 1'b1;
    case (paddr_in)
      rre_pkg::OFF_INSTR:     read_mux = {16'h0, opcode};
      rre_pkg::OFF_CTRL:      read_mux = {29'h0, stk_flag, ill_flag, busy};
      rre_pkg::OFF_ACC:       read_mux = {24'h0, accumulator};
      rre_pkg::OFF_FLAGS:     read_mux = {27'h0, flags};
      rre_pkg::OFF_BANK:      read_mux = {24'h0, bank_pointer};
      rre_pkg::OFF_PC:        read_mux = {11'h0, program_counter};
      rre_pkg::OFF_STACK:     read_mux = {11'h0, stack_head};
      rre_pkg::OFF_ACC_SH:    read_mux = {24'h0, accumulator_shadow};
      rre_pkg::OFF_FLAGS_SH:  read_mux = {27'h0, flags_shadow};
      rre_pkg::OFF_BANK_SH:   read_mux = {24'h0, bank_shadow};
      rre_pkg::OFF_UPPER:     read_mux = {24'h0, upper_jump_latch};
      rre_pkg::OFF_HIGH:      read_mux = {24'h0, high_jump_latch};
      rre_pkg::OFF_FILE_ADDR: read_mux = 32'(file_addr);
      rre_pkg::OFF_FILE_DATA: read_mux = {24'h0, mem_rdata};
      default:                mapped   = 1'b0;
    endcase
  end

  // Writes and file reads wait out a running instruction
  assign stall = busy & (pwrite_in | (paddr_in == rre_pkg::OFF_FILE_DATA));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end else begin
      pready_out  <= apb_access & ~pready_out & ~stall;
      pslverr_out <= apb_access & ~pready_out & ~stall & ~mapped;
      if (apb_access & ~pready_out & ~stall & ~pwrite_in) begin
        prdata_out <= read_mux;
      end
    end
  end

endmodule

// ---- dv/rre_exec_monitor.sv ----
/*
  Checker for the return and rotate execute block, bound to its APB ports.
  Assumes one clock and a synchronous active-high reset on rst_in.
*/
`timescale 1ns/1ns
module rre_exec_monitor (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // APB request
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  // APB answer
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // Cycles since the last instruction write
  // ----------------------------------------------------------------
  logic [3:0] since_op;
  logic       op_ret;
  logic       op_rot;
  logic       instr_wr;
  logic       ctrl_rd;
  assign instr_wr = psel_in && penable_in && pready_out && pwrite_in
                    && paddr_in == rre_pkg::OFF_INSTR;
  assign ctrl_rd  = psel_in && penable_in && pready_out && !pwrite_in
                    && paddr_in == rre_pkg::OFF_CTRL;

  // Saturates so stale instructions never match a window
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      since_op <= 4'hf;
      op_ret   <= 1'b0;
      op_rot   <= 1'b0;
    end else if (instr_wr) begin
      since_op <= 4'h1;
      op_ret   <= pwdata_in[15:1] == rre_pkg::OP_RET_PAT;
      op_rot   <= pwdata_in[15:10] == rre_pkg::OP_ROT_PAT;
    end else if (since_op != 4'hf) begin
      since_op <= since_op + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_UNMAPPED: assert property (pready_out && paddr_in > 8'h34
    |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (pready_out && paddr_in <= 8'h34 && paddr_in[1:0] == 2'h0
    |-> !pslverr_out)
    else $error("mapped access refused");
  AST_CTRL_FAST: assert property (psel_in && penable_in && !pready_out && !pwrite_in
    && paddr_in == rre_pkg::OFF_CTRL |=> pready_out)
    else $error("control read stalled");
  AST_RET_BUSY: assert property (ctrl_rd && op_ret && since_op inside {[3:8]}
    |-> prdata_out[rre_pkg::CTRL_BUSY_BIT])
    else $error("return not busy in its second cycle");
  AST_RET_DONE: assert property (ctrl_rd && op_ret && since_op inside {[12:14]}
    |-> !prdata_out[rre_pkg::CTRL_BUSY_BIT])
    else $error("return longer than two cycles");
  AST_ROT_DONE: assert property (ctrl_rd && op_rot && since_op inside {[8:14]}
    |-> !prdata_out[rre_pkg::CTRL_BUSY_BIT])
    else $error("rotate longer than one cycle");
endmodule

bind rre_exec rre_exec_monitor i_rre_exec_monitor (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));

// ---- dv/tb_top.sv ----
/*
  Self-checking bench for the return and rotate execute block over APB.
  Assumes the block answers every transfer; a cycle ceiling cuts hangs.
*/
`timescale 1ns/1ns
module tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;

  rre_exec i_rre_exec (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out));

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= addr;
    pwdata_in <= data;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(nm, exp, rd);
  endtask

  // Busy polling is bounded; a stuck flag shows as a mismatch later
  task automatic exec(input logic [15:0] op);
    int n;
    apb(1'b1, rre_pkg::OFF_INSTR, {16'h0000, op});
    n = 0;
    do begin
      apb(1'b0, rre_pkg::OFF_CTRL, 32'h0);
      n++;
    end while (rd[rre_pkg::CTRL_BUSY_BIT] !== 1'b0 && n < 20);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 8; a <= 44; a += 4) begin
      rdc("reset value", 8'(a), 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, 8'h44, 32'h5);
    chk("unmapped write error", 32'h1, {31'h0, err});
  endtask

  task automatic t_rotate();
    logic [15:0] op [3] = '{16'h3410, 16'h3710, 16'h3690};
    logic [11:0] fa [3] = '{12'h010, 12'h510, 12'hf90};
    logic [7:0]  v  [3] = '{8'he6, 8'h80, 8'h41};
    logic        ci [3] = '{1'b0, 1'b0, 1'b1};
    logic [7:0]  res;
    apb(1'b1, rre_pkg::OFF_BANK, 32'h5);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, rre_pkg::OFF_FILE_ADDR, {20'h0, fa[i]});
      apb(1'b1, rre_pkg::OFF_FILE_DATA, {24'h0, v[i]});
    end
    for (int i = 0; i < 3; i++) begin
      res = {v[i][6:0], ci[i]};
      apb(1'b1, rre_pkg::OFF_ACC, 32'h5a);
      apb(1'b1, rre_pkg::OFF_FLAGS, {27'h0, 4'h4, ci[i]});
      exec(op[i]);
      rdc("accumulator", rre_pkg::OFF_ACC, op[i][9] ? 32'h5a : {24'h0, res});
      apb(1'b1, rre_pkg::OFF_FILE_ADDR, {20'h0, fa[i]});
      rdc("file byte", rre_pkg::OFF_FILE_DATA, {24'h0, op[i][9] ? res : v[i]});
      rdc("flags", rre_pkg::OFF_FLAGS, {27'h0, res[7], 1'b1, res == 8'h0, 1'b0, v[i][7]});
      rdc("control", rre_pkg::OFF_CTRL, 32'h0);
    end
  endtask

  task automatic t_return();
    logic [7:0]  ad [8] = '{8'h08, 8'h0c, 8'h10, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
    logic [31:0] dv [8] = '{32'h11, 32'h0a, 32'h3, 32'h55, 32'h15, 32'h7, 32'h1f, 32'ha5};
    apb(1'b1, rre_pkg::OFF_STACK, 32'h012345);
    apb(1'b1, rre_pkg::OFF_STACK, 32'h1abcde);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ad[i], dv[i]);
    end
    exec(16'h0012);
    rdc("pc", rre_pkg::OFF_PC, 32'h1abcde);
    rdc("stack head", rre_pkg::OFF_STACK, 32'h012345);
    rdc("accumulator", rre_pkg::OFF_ACC, 32'h11);
    rdc("flags", rre_pkg::OFF_FLAGS, 32'h0a);
    rdc("bank", rre_pkg::OFF_BANK, 32'h3);
    exec(16'h0013);
    rdc("pc", rre_pkg::OFF_PC, 32'h012345);
    rdc("accumulator", rre_pkg::OFF_ACC, 32'h55);
    rdc("flags", rre_pkg::OFF_FLAGS, 32'h15);
    rdc("bank", rre_pkg::OFF_BANK, 32'h7);
    rdc("upper latch", rre_pkg::OFF_UPPER, 32'h1f);
    rdc("high latch", rre_pkg::OFF_HIGH, 32'ha5);
    rdc("control", rre_pkg::OFF_CTRL, 32'h0);
    exec(16'h0012);
    rdc("empty pop pc", rre_pkg::OFF_PC, 32'h0);
    rdc("stack error", rre_pkg::OFF_CTRL, 32'h4);
    apb(1'b1, rre_pkg::OFF_CTRL, 32'h4);
    rdc("stack error cleared", rre_pkg::OFF_CTRL, 32'h0);
  endtask

  task automatic t_decode();
    apb(1'b1, rre_pkg::OFF_STACK, 32'h000777);
    apb(1'b1, rre_pkg::OFF_ACC, 32'h81);
    exec(16'h0010);
    rdc("near return head", rre_pkg::OFF_STACK, 32'h000777);
    rdc("near return illegal", rre_pkg::OFF_CTRL, 32'h2);
    exec(16'h3810);
    rdc("near rotate acc", rre_pkg::OFF_ACC, 32'h81);
    apb(1'b1, rre_pkg::OFF_CTRL, 32'h2);
    exec(16'h0013);
    rdc("return pc", rre_pkg::OFF_PC, 32'h000777);
    rdc("control", rre_pkg::OFF_CTRL, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_rotate();
    t_return();
    t_decode();
    print_verdict();
  end
endmodule
